// >>> design/btzm_cfg.svh
// Constants of the battery temperature zone monitor: register offsets,
// field positions, reset values, trip level table and channel codes.
// Included by every design file that decodes registers or trip levels.
`ifndef BTZM_CFG_SVH
`define BTZM_CFG_SVH

`define BTZM_OFS_CTRL 12'h000
`define BTZM_OFS_CHG 12'h004
`define BTZM_OFS_STAT 12'h008

`define BTZM_CTRL_EN 0
`define BTZM_CTRL_MASK 1
`define BTZM_CTRL_MUX_LSB 4
`define BTZM_CTRL_TRIP_LSB 8

`define BTZM_CHG_NV_LSB 0
`define BTZM_CHG_NI_LSB 8
`define BTZM_CHG_MV_LSB 16
`define BTZM_CHG_MI_LSB 24

`define BTZM_STAT_FAULT 4
`define BTZM_STAT_MOD 5
`define BTZM_STAT_IRQ 8

`define BTZM_RST_EN 1'h0
`define BTZM_RST_MASK 1'h1
`define BTZM_RST_MUX 4'h0
`define BTZM_RST_TRIP 8'h17
`define BTZM_RST_CHG 32'h0000_0000

`define BTZM_MUX_THM 4'h7
`define BTZM_MUX_SENSOR_BIAS_NODE 4'h8

// Trip levels in millivolts, cold end first
`define BTZM_LVL_0 11'h400
`define BTZM_LVL_1 11'h3D0
`define BTZM_LVL_2 11'h39B
`define BTZM_LVL_3 11'h363
`define BTZM_LVL_4 11'h327
`define BTZM_LVL_5 11'h2EB
`define BTZM_LVL_6 11'h1FF
`define BTZM_LVL_7 11'h1CB
`define BTZM_LVL_8 11'h19B
`define BTZM_LVL_9 11'h16F
`define BTZM_LVL_10 11'h147
`define BTZM_LVL_11 11'h123

`define BTZM_BASE_COLD 4'h0
`define BTZM_BASE_COOL 4'h2
`define BTZM_BASE_WARM 4'h6
`define BTZM_BASE_HOT 4'h8

`define BTZM_FLT_NONE 2'h0
`define BTZM_FLT_PQ 2'h1
`define BTZM_FLT_FC 2'h2
`define BTZM_FLT_TEMP 2'h3

`define BTZM_DEBOUNCE 4

`endif

// >>> design/btzm_pkg.sv
// Types shared by the temperature zone monitor files.
// Assumes nothing beyond a SystemVerilog compiler.
package btzm_pkg;

  typedef enum logic [2:0] {
    BTZM_Z_OFF = 3'h0,
    BTZM_Z_COLD = 3'h1,
    BTZM_Z_COOL = 3'h2,
    BTZM_Z_NORM = 3'h3,
    BTZM_Z_WARM = 3'h4,
    BTZM_Z_HOT = 3'h5
  } btzm_zone_t;

  typedef enum logic [2:0] {
    BTZM_S_NORM = 3'b001,
    BTZM_S_MOD = 3'b010,
    BTZM_S_FAULT = 3'b100
  } btzm_st_t;

  typedef struct packed {
    logic [1:0] cold;
    logic [1:0] cool;
    logic [1:0] warm;
    logic [1:0] hot;
  } btzm_trip_sel_t;

  typedef struct packed {
    logic [5:0] volt;
    logic [5:0] curr;
  } btzm_setting_t;

endpackage

// >>> design/btzm_zone_decode.sv
// Four trip comparators and the zone classifier of the monitor.
// Assumes a sensor level in millivolts, synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "btzm_cfg.svh"

module btzm_zone_decode
  import btzm_pkg::*;
#(
  parameter int LEVEL_W = 11
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [LEVEL_W-1:0] level_mv,
  input wire btzm_trip_sel_t trip_sel,
  output btzm_zone_t zone_q
);

  function automatic logic [10:0] trip_mv(input logic [3:0] idx);
    case (idx)
      4'h0: trip_mv = `BTZM_LVL_0;
      4'h1: trip_mv = `BTZM_LVL_1;
      4'h2: trip_mv = `BTZM_LVL_2;
      4'h3: trip_mv = `BTZM_LVL_3;
      4'h4: trip_mv = `BTZM_LVL_4;
      4'h5: trip_mv = `BTZM_LVL_5;
      4'h6: trip_mv = `BTZM_LVL_6;
      4'h7: trip_mv = `BTZM_LVL_7;
      4'h8: trip_mv = `BTZM_LVL_8;
      4'h9: trip_mv = `BTZM_LVL_9;
      4'hA: trip_mv = `BTZM_LVL_10;
      default: trip_mv = `BTZM_LVL_11;
    endcase
  endfunction

  localparam logic [3:0] BASE [4] = '{`BTZM_BASE_COLD, `BTZM_BASE_COOL,
                                      `BTZM_BASE_WARM, `BTZM_BASE_HOT};

  logic [3:0] trip_hit;
  btzm_zone_t zone_d;

  // Index 0 cold, 1 cool, 2 warm, 3 hot
  for (genvar i = 0; i < 4; i++) begin : g_cmp
    logic [1:0] sel;
    logic [10:0] trip;
    assign sel = trip_sel[7-2*i -: 2];
    assign trip = trip_mv(BASE[i] + {2'h0, sel});
    if (i < 2) begin : g_cold_side
      assign trip_hit[i] = level_mv > trip;
    end else begin : g_hot_side
      assign trip_hit[i] = level_mv < trip;
    end
  end

  always_comb begin
    if (trip_hit[0]) zone_d = BTZM_Z_COLD;
    else if (trip_hit[3]) zone_d = BTZM_Z_HOT;
    else if (trip_hit[1]) zone_d = BTZM_Z_COOL;
    else if (trip_hit[2]) zone_d = BTZM_Z_WARM;
    else zone_d = BTZM_Z_NORM;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) zone_q <= BTZM_Z_NORM;
    else zone_q <= zone_d;
  end

endmodule // btzm_zone_decode
`default_nettype wire

// >>> design/btzm_top.sv
// Battery temperature zone monitor: APB registers, zone status and change
// flag, charge setting selection, temperature fault handling, bias control.
// Assumes a digitised sensor level in millivolts and a charger core that
// follows the pause, clear and resume outputs.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "btzm_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module btzm_top
  import btzm_pkg::*;
#(
  parameter int LEVEL_W = 11,
  parameter int PHASE_W = 4,
  parameter int DEBOUNCE_CYC = `BTZM_DEBOUNCE
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LEVEL_W-1:0] sensor_level_mv,
  input wire logic charger_supply_valid,
  input wire logic [PHASE_W-1:0] chg_phase,
  input wire logic pq_timer_fault,
  input wire logic fc_timer_fault,
  output logic temp_zone_change_irq,
  output logic sensor_bias_on,
  output logic [3:0] probe_select,
  output logic [5:0] charge_voltage,
  output logic [5:0] charge_current,
  output logic charge_pause,
  output logic modified_mode,
  output logic temp_fault,
  output logic [1:0] active_fault,
  output logic timers_pause,
  output logic fc_timer_clear,
  output logic topoff_timer_clear,
  output logic resume_strobe,
  output logic [PHASE_W-1:0] resume_phase
);

  //////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'h1};
  end

  assign rst_n = rst_sync_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state so read data come from a register

  logic [15:0] ctrl_q, ctrl_d;
  logic [31:0] chg_q, chg_d;
  logic irq_q, irq_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic acc, done, hit_ctrl, hit_chg, hit_stat, mapped;
  logic [31:0] wmask, rd_word;
  logic en;
  logic zone_chg;
  btzm_zone_t stat_q, stat_d;
  btzm_st_t st_q, st_d;

  assign acc = psel & penable;
  assign done = acc & pready_q;
  assign hit_ctrl = paddr == `BTZM_OFS_CTRL;
  assign hit_chg = paddr == `BTZM_OFS_CHG;
  assign hit_stat = paddr == `BTZM_OFS_STAT;
  assign mapped = hit_ctrl | hit_chg | hit_stat;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign en = ctrl_q[`BTZM_CTRL_EN];

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_ctrl) rd_word = {16'h0000, ctrl_q};
    else if (hit_chg) rd_word = chg_q;
    else if (hit_stat) begin
      rd_word = {23'h000000, irq_q, 2'h0, st_q == BTZM_S_MOD, st_q == BTZM_S_FAULT,
                 1'h0, stat_q};
    end
  end

  always_comb begin
    pready_d = acc & ~pready_q;
    pslverr_d = acc & ~pready_q & ~mapped;
    prdata_d = (acc & ~pready_q & ~pwrite) ? rd_word : 32'h0000_0000;
    ctrl_d = ctrl_q;
    chg_d = chg_q;
    if (done & pwrite & hit_ctrl) begin
      ctrl_d = (ctrl_q & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
      ctrl_d[3:2] = 2'h0;
    end
    if (done & pwrite & hit_chg) begin
      chg_d = (chg_q & ~wmask) | (pwdata & wmask);
    end
    // Set wins over a write-one clear in the same cycle
    irq_d = zone_chg |
            (irq_q & ~(done & pwrite & hit_stat & pstrb[1] & pwdata[`BTZM_STAT_IRQ]));
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= {`BTZM_RST_TRIP, `BTZM_RST_MUX, 2'h0, `BTZM_RST_MASK, `BTZM_RST_EN};
      chg_q <= `BTZM_RST_CHG;
      irq_q <= 1'h0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
    end else begin
      ctrl_q <= ctrl_d;
      chg_q <= chg_d;
      irq_q <= irq_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Zone classification with debounce
  // Comparator chatter near a trip level would otherwise toggle the charger
  // between settings; a zone must hold DEBOUNCE_CYC + 2 cycles to be accepted.

  btzm_zone_t raw_zone, cand_q, cand_d;
  logic [7:0] stab_q, stab_d;

  // The probe select is not an input here, so the mux cannot disturb it
  btzm_zone_decode #(
    .LEVEL_W(LEVEL_W)
  ) u_decode (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .level_mv(sensor_level_mv),
    .trip_sel(btzm_trip_sel_t'(ctrl_q[15:8])),
    .zone_q(raw_zone)
  );

  always_comb begin
    cand_d = raw_zone;
    stab_d = 8'h00;
    if (raw_zone == cand_q) begin
      stab_d = (stab_q == 8'(DEBOUNCE_CYC)) ? stab_q : stab_q + 8'h01;
    end
    stat_d = stat_q;
    if (!en) stat_d = BTZM_Z_OFF;
    else if (raw_zone == cand_q && stab_q == 8'(DEBOUNCE_CYC)) stat_d = cand_q;
    else if (stat_q == BTZM_Z_OFF) stat_d = BTZM_Z_OFF;
    zone_chg = stat_d != stat_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cand_q <= BTZM_Z_NORM;
      stab_q <= 8'h00;
      stat_q <= BTZM_Z_OFF;
    end else begin
      cand_q <= cand_d;
      stab_q <= stab_d;
      stat_q <= stat_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Charger temperature state

  logic [PHASE_W-1:0] saved_q, saved_d;
  btzm_setting_t norm_set, mod_set, set_d;
  logic leaving;
  logic [1:0] fault_d;
  logic [5:0] cv_q, cc_q;
  logic pause_q, mod_q, fault_q, tpause_q, fcclr_q, toclr_q, resume_q;
  logic [1:0] afault_q;
  logic [PHASE_W-1:0] rphase_q;

  assign norm_set = {chg_q[`BTZM_CHG_NV_LSB +: 6], chg_q[`BTZM_CHG_NI_LSB +: 6]};
  assign mod_set = {chg_q[`BTZM_CHG_MV_LSB +: 6], chg_q[`BTZM_CHG_MI_LSB +: 6]};

  always_comb begin
    st_d = st_q;
    case (stat_q)
      BTZM_Z_HOT, BTZM_Z_COLD: st_d = BTZM_S_FAULT;
      BTZM_Z_WARM, BTZM_Z_COOL: st_d = BTZM_S_MOD;
      BTZM_Z_NORM: st_d = BTZM_S_NORM;
      default: st_d = BTZM_S_NORM;
    endcase
    saved_d = saved_q;
    if (st_d == BTZM_S_FAULT && st_q != BTZM_S_FAULT) saved_d = chg_phase;
    leaving = st_q == BTZM_S_FAULT && st_d != BTZM_S_FAULT;
    set_d = (st_d == BTZM_S_MOD) ? mod_set : norm_set;
    if (st_d == BTZM_S_FAULT) fault_d = `BTZM_FLT_TEMP;
    else if (pq_timer_fault) fault_d = `BTZM_FLT_PQ;
    else if (fc_timer_fault) fault_d = `BTZM_FLT_FC;
    else fault_d = `BTZM_FLT_NONE;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= BTZM_S_NORM;
      saved_q <= '0;
      cv_q <= 6'h00;
      cc_q <= 6'h00;
      pause_q <= 1'h0;
      mod_q <= 1'h0;
      fault_q <= 1'h0;
      tpause_q <= 1'h0;
      fcclr_q <= 1'h0;
      toclr_q <= 1'h0;
      resume_q <= 1'h0;
      rphase_q <= '0;
      afault_q <= `BTZM_FLT_NONE;
    end else begin
      st_q <= st_d;
      saved_q <= saved_d;
      cv_q <= set_d.volt;
      cc_q <= set_d.curr;
      pause_q <= st_d == BTZM_S_FAULT;
      mod_q <= st_d == BTZM_S_MOD;
      fault_q <= st_d == BTZM_S_FAULT;
      tpause_q <= st_d == BTZM_S_FAULT;
      fcclr_q <= leaving;
      toclr_q <= leaving;
      resume_q <= leaving;
      rphase_q <= saved_q;
      afault_q <= fault_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bias and interrupt

  logic bias_q, bias_d;
  logic irq_out_q;
  logic [3:0] mux_sel;

  assign mux_sel = ctrl_q[`BTZM_CTRL_MUX_LSB +: 4];

  always_comb begin
    bias_d = (charger_supply_valid & en) |
             (mux_sel == `BTZM_MUX_THM) | (mux_sel == `BTZM_MUX_SENSOR_BIAS_NODE);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bias_q <= 1'h0;
      irq_out_q <= 1'h0;
    end else begin
      bias_q <= bias_d;
      irq_out_q <= irq_d & ~ctrl_d[`BTZM_CTRL_MASK];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign temp_zone_change_irq = irq_out_q;
  assign sensor_bias_on = bias_q;
  assign probe_select = ctrl_q[`BTZM_CTRL_MUX_LSB +: 4];
  assign charge_voltage = cv_q;
  assign charge_current = cc_q;
  assign charge_pause = pause_q;
  assign modified_mode = mod_q;
  assign temp_fault = fault_q;
  assign active_fault = afault_q;
  assign timers_pause = tpause_q;
  assign fc_timer_clear = fcclr_q;
  assign topoff_timer_clear = toclr_q;
  assign resume_strobe = resume_q;
  assign resume_phase = rphase_q;

endmodule // btzm_top
`default_nettype wire

// >>> verification/btzm_properties.sv
// Checker of the temperature zone monitor's port behaviour.
// Assumes the top module's ports; attached by the bind at the foot.
`timescale 1ns/10ps
`default_nettype none
module btzm_properties
  import btzm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic [3:0] probe_select,
  input wire logic sensor_bias_on,
  input wire logic charge_pause,
  input wire logic modified_mode,
  input wire logic temp_fault,
  input wire logic [1:0] active_fault,
  input wire logic timers_pause,
  input wire logic fc_timer_clear,
  input wire logic topoff_timer_clear,
  input wire logic resume_strobe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  // Probe must stay on a sensor channel two edges, to cover the one-cycle bias latency
  sequence s_probe;
    (probe_select == 4'h7 || probe_select == 4'h8) [*2];
  endsequence
  // Both timer clears pulse in the same cycle that the fault drops
  sequence s_exit;
    fc_timer_clear && topoff_timer_clear;
  endsequence
  a_apb_wait: assert property (s_setup |=> s_answer)
    else $error("pready not in second access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_fault_outputs: assert property (temp_fault |-> active_fault == 2'h3)
    else $error("temperature fault not top priority");
  a_pause_match: assert property ({charge_pause, timers_pause} == {2{temp_fault}})
    else $error("pause outputs differ from fault");
  a_mode_exclusive: assert property (modified_mode |-> !temp_fault)
    else $error("modified mode during fault");
  a_exit_pulses: assert property ($fell(temp_fault) |-> s_exit)
    else $error("timers not cleared on fault exit");
  a_strobe_cause: assert property (resume_strobe |-> $past(temp_fault) && !temp_fault)
    else $error("resume strobe without fault exit");
  a_strobe_once: assert property (resume_strobe |=> !resume_strobe)
    else $error("resume strobe longer than one cycle");
  a_bias_probe: assert property (s_probe |-> sensor_bias_on)
    else $error("bias off while probe on sensor");
endmodule // btzm_properties

bind btzm_top btzm_properties btzm_properties_inst (
  .clk_sys, .rstn, .psel, .penable, .pready, .pslverr, .prdata, .probe_select,
  .sensor_bias_on, .charge_pause, .modified_mode, .temp_fault, .active_fault,
  .timers_pause, .fc_timer_clear, .topoff_timer_clear, .resume_strobe
);
`default_nettype wire

// >>> verification/btzm_ntc_model.sv
// Thermistor network on the battery, seen as a digitised node level.
// Assumes the bench sets the level that the temperature would give.
`timescale 1ns/10ps
`default_nettype none
module btzm_ntc_model (
  input wire logic clk_sys,
  input wire logic bias_on,
  input wire logic [10:0] target_mv,
  output logic [10:0] level_mv
);
  // Unbiased node is pulled to ground, which reads as hottest
  always_ff @(posedge clk_sys) begin
    level_mv <= bias_on ? target_mv : 11'h000;
  end
endmodule // btzm_ntc_model
`default_nettype wire

// >>> verification/tb_top.sv
// Bench of the temperature zone monitor: random levels and trips over APB.
// Assumes the design, the sensor model and the checker compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import btzm_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, chg;
  logic pready, pslverr, er, irq, bias, pause, modm, tflt, rstb;
  logic supply = 1'b1;
  logic pq_f = 1'b0;
  logic [10:0] level;
  logic [10:0] target = 11'h258;
  logic [3:0] phase = 4'h0;
  logic [3:0] probe, rphase, got_ph, eph, pm;
  logic ch, fz, mz;
  logic [11:0] exp_set;
  logic [5:0] cv, cc;
  logic [1:0] afault;
  btzm_trip_sel_t trip;
  btzm_zone_t ez, pz;
  int fail_count = 0;
  int cmp_count = 0;
  int pulses = 0;
  int np;
  logic [10:0] lv [12] = '{11'h400, 11'h3D0, 11'h39B, 11'h363, 11'h327, 11'h2EB,
                           11'h1FF, 11'h1CB, 11'h19B, 11'h16F, 11'h147, 11'h123};

  btzm_top #(.DEBOUNCE_CYC(1)) btzm_top_inst (
    .clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .sensor_level_mv(level), .charger_supply_valid(supply),
    .chg_phase(phase), .pq_timer_fault(pq_f), .fc_timer_fault(1'b0),
    .temp_zone_change_irq(irq), .sensor_bias_on(bias), .probe_select(probe),
    .charge_voltage(cv), .charge_current(cc), .charge_pause(pause),
    .modified_mode(modm), .temp_fault(tflt), .active_fault(afault), .timers_pause(),
    .fc_timer_clear(), .topoff_timer_clear(), .resume_strobe(rstb), .resume_phase(rphase)
  );
  btzm_ntc_model btzm_ntc_model_inst (
    .clk_sys, .bias_on(bias), .target_mv(target), .level_mv(level)
  );

  ////////////////////////////////////////
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (rstb) begin
      pulses <= pulses + 1;
      got_ph <= rphase;
    end
  end

  function automatic logic isf(btzm_zone_t z);
    return z == BTZM_Z_HOT || z == BTZM_Z_COLD;
  endfunction
  function automatic logic md(btzm_zone_t z);
    return z == BTZM_Z_COOL || z == BTZM_Z_WARM;
  endfunction
  // Higher level is colder; cold and hot outrank cool and warm
  function automatic btzm_zone_t zone_of(logic [10:0] v, btzm_trip_sel_t t);
    if (v > lv[t.cold]) return BTZM_Z_COLD;
    if (v < lv[8 + t.hot]) return BTZM_Z_HOT;
    if (v > lv[2 + t.cool]) return BTZM_Z_COOL;
    if (v < lv[6 + t.warm]) return BTZM_Z_WARM;
    return BTZM_Z_NORM;
  endfunction

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Entered just after an edge; leaves one idle edge so psel is never set twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(1'b0, "no pready");
    @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd === x && er === 1'b0, "register read");
  endtask

  initial begin
    #500us;
    fail_count++;
    conclude();
  end

  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hF6CA));
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdc(12'h000, 32'h0000_1702);
    rdc(12'h004, 32'h0);
    apb(1'b1, 12'h008, 32'h0000_0035, rd, er);
    rdc(12'h008, 32'h0);
    apb(1'b0, 12'h00C, 32'h0, rd, er);
    chk(er === 1'b1 && rd === 32'h0, "unmapped");
    for (int i = 0; i < 48; i++) begin
      if (i % 8 == 0) begin
        // A level that is normal under every trip choice
        target <= 11'h258;
        repeat (12) @(posedge clk_sys);
        trip = btzm_trip_sel_t'(8'($urandom));
        apb(1'b1, 12'h000, {16'h0, trip, 4'($urandom), 4'h1}, rd, er);
        chg = $urandom;
        apb(1'b1, 12'h004, chg, rd, er);
        repeat (12) @(posedge clk_sys);
        apb(1'b1, 12'h008, 32'h100, rd, er);
        pz = BTZM_Z_NORM;
        np = pulses;
      end
      phase <= 4'($urandom);
      target <= ($urandom_range(3, 0) == 0) ? 11'($urandom_range(1100, 200))
                : lv[$urandom_range(11, 0)] + 11'($urandom_range(2, 0)) - 11'h1;
      repeat (12) @(posedge clk_sys);
      ez = zone_of(target, trip);
      ch = ez != pz;
      fz = isf(ez);
      mz = md(ez);
      exp_set = mz ? {chg[21:16], chg[29:24]} : {chg[5:0], chg[13:8]};
      if (fz && !isf(pz)) eph = phase;
      apb(1'b0, 12'h008, 32'h0, rd, er);
      chk({rd[8], rd[5:4], rd[2:0]} === {ch, mz, fz, ez}, "status");
      chk({irq, tflt, pause, modm} === {ch, fz, fz, mz}, "outputs");
      if (!fz) chk({cv, cc} === exp_set, "settings");
      if (isf(pz) && !fz) chk(pulses == np + 1 && got_ph === eph, "resume");
      np = pulses;
      apb(1'b1, 12'h008, 32'h100, rd, er);
      chk(irq === 1'b0, "irq clear");
      pz = ez;
    end
    target <= 11'h050;
    pq_f <= 1'b1;
    repeat (12) @(posedge clk_sys);
    chk(tflt === 1'b1 && afault === 2'h3, "fault priority");
    for (int j = 0; j < 12; j++) begin
      supply <= j[1];
      pm = (j < 4) ? 4'h0 : (j < 8) ? 4'h7 : 4'h8;
      apb(1'b1, 12'h000, {16'h0, trip, pm, 3'h0, j[0]}, rd, er);
      repeat (12) @(posedge clk_sys);
      chk(bias === (j[0] & j[1] | j >= 4), "bias");
      chk(probe === pm, "probe select");
      // Sensor stays far below every hot trip, so the fault must hold whatever the mux while the monitor is enabled
      if (!j[0]) chk({tflt, pause, modm, afault} === 5'b00001, "disabled");
      else chk(tflt === 1'b1 && afault === 2'h3, "mux apart");
    end
    conclude();
  end
endmodule // tb_top
`default_nettype wire
